// file: hw/lcdcrl_defines.svh
`ifndef LCDCRL_DEFINES_SVH
`define LCDCRL_DEFINES_SVH

// ****************************************
// command codes
// ****************************************
`define LCDCRL_CODE_INIT        8'h40
`define LCDCRL_CODE_MEM_WRITE   8'h42
`define LCDCRL_CODE_SCROLL      8'h44
`define LCDCRL_CODE_CSR_LOAD    8'h46
`define LCDCRL_CODE_STEP_BASE   8'h4C
`define LCDCRL_CODE_STEP_MASK   8'hFC
`define LCDCRL_CODE_DISP_OFF    8'h58
`define LCDCRL_CODE_DISP_ON     8'h59
`define LCDCRL_CODE_HSHIFT      8'h5A
`define LCDCRL_CODE_LAYER       8'h5B
`define LCDCRL_CODE_CSR_SHAPE   8'h5D

// ****************************************
// register offsets
// ****************************************
`define LCDCRL_OFS_MODE         5'h00
`define LCDCRL_OFS_CHAR_WIDTH   5'h01
`define LCDCRL_OFS_CHAR_HEIGHT  5'h02
`define LCDCRL_OFS_LINE_ADDR    5'h03
`define LCDCRL_OFS_LINE_TOTAL   5'h04
`define LCDCRL_OFS_FRAME_LINES  5'h05
`define LCDCRL_OFS_PITCH_LOW    5'h06
`define LCDCRL_OFS_PITCH_HIGH   5'h07
`define LCDCRL_OFS_DISP_ENABLE  5'h09
`define LCDCRL_OFS_ATTRIBUTE    5'h0A
`define LCDCRL_OFS_BLK1_LOW     5'h0B
`define LCDCRL_OFS_BLK1_HIGH    5'h0C
`define LCDCRL_OFS_BLK1_LINES   5'h0D
`define LCDCRL_OFS_BLK2_LOW     5'h0E
`define LCDCRL_OFS_BLK2_HIGH    5'h0F
`define LCDCRL_OFS_BLK2_LINES   5'h10
`define LCDCRL_OFS_BLK3_LOW     5'h11
`define LCDCRL_OFS_BLK3_HIGH    5'h12
`define LCDCRL_OFS_BLK4_LOW     5'h13
`define LCDCRL_OFS_BLK4_HIGH    5'h14
`define LCDCRL_OFS_CSR_WIDTH    5'h15
`define LCDCRL_OFS_CSR_HEIGHT   5'h16
`define LCDCRL_OFS_CURSOR_STEP_CMD      5'h17
`define LCDCRL_OFS_LAYER        5'h18
`define LCDCRL_OFS_HSHIFT       5'h1B
`define LCDCRL_OFS_CSR_LOW      5'h1C
`define LCDCRL_OFS_CSR_HIGH     5'h1D

// ****************************************
// parameter counts, masks, reset value
// ****************************************
`define LCDCRL_CNT_INIT         4'h8
`define LCDCRL_CNT_SCROLL       4'hA
`define LCDCRL_CNT_ONE          4'h1
`define LCDCRL_CNT_TWO          4'h2
`define LCDCRL_MASK_HSHIFT      8'h07
`define LCDCRL_REG_RESET        8'h00

`endif

// file: hw/lcdcrl_pkg.sv
package lcdcrl_pkg;

  typedef enum logic [3:0] {
    LCDCRL_IDLE      = 4'b0000,
    LCDCRL_INIT      = 4'b0001,
    LCDCRL_SCROLL    = 4'b0010,
    LCDCRL_HSHIFT    = 4'b0011,
    LCDCRL_LAYER     = 4'b0100,
    LCDCRL_DISP      = 4'b0101,
    LCDCRL_CSR_LOAD  = 4'b0110,
    LCDCRL_CSR_SHAPE = 4'b0111,
    LCDCRL_CSR_STEP  = 4'b1000,
    LCDCRL_MEM_WRITE = 4'b1001,
    LCDCRL_UNKNOWN   = 4'b1010
  } lcdcrl_cmd_type;

  typedef struct packed {
    lcdcrl_cmd_type cmd;
    logic [4:0]     base;
    logic [3:0]     count;
  } lcdcrl_decode_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       cmd_param_select;
    logic [7:0] data;
  } lcdcrl_host_type;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [7:0]  data;
  } lcdcrl_mem_type;

  typedef struct packed {
    logic [31:0][7:0] regs;
    lcdcrl_cmd_type   cmd;
    logic [4:0]       base;
    logic [3:0]       count;
    logic [3:0]       param_idx;
    lcdcrl_mem_type   mem;
    logic [7:0]       rd_data;
    logic             rd_high;
  } lcdcrl_state_type;

endpackage

// file: hw/lcdcrl_decoder.sv
`timescale 1ns/1ps
`include "lcdcrl_defines.svh"

module lcdcrl_decoder (
  // command byte
  input  wire logic [7:0]                code,
  // decoded command
  output lcdcrl_pkg::lcdcrl_decode_type  dec
);

  always_comb begin
    dec.base  = `LCDCRL_OFS_MODE;
    dec.count = 4'h0;
    if ((code & `LCDCRL_CODE_STEP_MASK) == `LCDCRL_CODE_STEP_BASE) begin
      dec.cmd = lcdcrl_pkg::LCDCRL_CSR_STEP;
    end else begin
      case (code)
        `LCDCRL_CODE_INIT: begin
          dec.cmd   = lcdcrl_pkg::LCDCRL_INIT;
          dec.count = `LCDCRL_CNT_INIT;
        end
        `LCDCRL_CODE_SCROLL: begin
          dec.cmd   = lcdcrl_pkg::LCDCRL_SCROLL;
          dec.base  = `LCDCRL_OFS_BLK1_LOW;
          dec.count = `LCDCRL_CNT_SCROLL;
        end
        `LCDCRL_CODE_HSHIFT: begin
          dec.cmd   = lcdcrl_pkg::LCDCRL_HSHIFT;
          dec.base  = `LCDCRL_OFS_HSHIFT;
          dec.count = `LCDCRL_CNT_ONE;
        end
        `LCDCRL_CODE_LAYER: begin
          dec.cmd   = lcdcrl_pkg::LCDCRL_LAYER;
          dec.base  = `LCDCRL_OFS_LAYER;
          dec.count = `LCDCRL_CNT_ONE;
        end
        `LCDCRL_CODE_DISP_OFF, `LCDCRL_CODE_DISP_ON: begin
          dec.cmd   = lcdcrl_pkg::LCDCRL_DISP;
          dec.base  = `LCDCRL_OFS_ATTRIBUTE;
          dec.count = `LCDCRL_CNT_ONE;
        end
        `LCDCRL_CODE_CSR_LOAD: begin
          dec.cmd   = lcdcrl_pkg::LCDCRL_CSR_LOAD;
          dec.base  = `LCDCRL_OFS_CSR_LOW;
          dec.count = `LCDCRL_CNT_TWO;
        end
        `LCDCRL_CODE_CSR_SHAPE: begin
          dec.cmd   = lcdcrl_pkg::LCDCRL_CSR_SHAPE;
          dec.base  = `LCDCRL_OFS_CSR_WIDTH;
          dec.count = `LCDCRL_CNT_TWO;
        end
        `LCDCRL_CODE_MEM_WRITE: dec.cmd = lcdcrl_pkg::LCDCRL_MEM_WRITE;
        default:                dec.cmd = lcdcrl_pkg::LCDCRL_UNKNOWN;
      endcase
    end
  end

endmodule

// file: hw/lcdcrl_stepper.sv
`timescale 1ns/1ps

module lcdcrl_stepper (
  // cursor and geometry
  input  wire logic [15:0] addr,
  input  wire logic [15:0] pitch,
  input  wire logic [1:0]  dir,
  // stepped cursor
  output logic      [15:0] next_addr
);

  // wraps modulo 64k, as the address space does
  always_comb begin
    case (dir)
      2'h0:    next_addr = addr + 16'h0001;
      2'h1:    next_addr = addr - 16'h0001;
      2'h2:    next_addr = addr - pitch;
      2'h3:    next_addr = addr + pitch;
      default: next_addr = addr;
    endcase
  end

endmodule

// file: hw/lcdcrl_top.sv
// Summary of operation
// RULE1 - init param two: width minus one, drive bit
// RULE2 - init param three: character height minus one
// RULE3 - init param four: addresses per line minus one
// RULE4 - init param five: total line address range
// RULE5 - init param six: frame lines minus one
// RULE6 - init params seven, eight: line pitch low, high
// RULE7 - scroll params one, two: block one start
// RULE8 - scroll param three: block one line count
// RULE9 - scroll params four to six: block two
// RULE10 - scroll params seven to ten: blocks three, four
// RULE11 - shift command: one param, shift bits 2-0
// RULE12 - layer command: combine operation bits 1-0
// RULE13 - layer param bit 2: block one mode
// RULE14 - display command code clears or sets enable
// RULE15 - display param: cursor blink rate bits 1-0
// RULE16 - display param: block attributes bits 7-2
// RULE17 - cursor load: two params, low then high
// RULE18 - cursor shape param one: width minus one
// RULE19 - cursor shape param two: height, block select
// RULE20 - step command: code bits set direction
// RULE21 - host clears layers before display on
// RULE22 - select high is command, low is parameter
// RULE23 - step code down advances by one pitch
// RULE24 - host waits after init code on crystal
// RULE25 - command restarts params, extras are ignored
`timescale 1ns/1ps
`include "lcdcrl_defines.svh"

module lcdcrl_top (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  // host parallel bus
  input  lcdcrl_pkg::lcdcrl_host_type    host,
  output logic [7:0]                     rd_data,
  // configuration seen by the scan engine
  output logic [3:0]                     char_width,
  output logic                           ac_drive_select,
  output logic [3:0]                     char_height,
  output logic [7:0]                     line_addr_count,
  output logic [7:0]                     line_total_count,
  output logic [7:0]                     frame_line_count,
  output logic [15:0]                    virtual_line_pitch,
  output logic                           display_enable,
  output logic [1:0]                     cursor_blink_rate,
  output logic [1:0]                     block1_attr,
  output logic [1:0]                     block2_4_attr,
  output logic [1:0]                     block3_attr,
  output logic [15:0]                    block1_start,
  output logic [7:0]                     block1_lines,
  output logic [15:0]                    block2_start,
  output logic [7:0]                     block2_lines,
  output logic [15:0]                    block3_start,
  output logic [15:0]                    block4_start,
  output logic [3:0]                     cursor_width,
  output logic [3:0]                     cursor_height,
  output logic                           cursor_shape_select,
  output logic [1:0]                     cursor_dir,
  output logic [1:0]                     layer_combine_op,
  output logic                           block1_text_graphics,
  output logic [2:0]                     fine_hshift,
  output logic [15:0]                    cursor_addr,
  // display memory write port
  output lcdcrl_pkg::lcdcrl_mem_type     mem
);

  // ****************************************
  // state and decode
  // ****************************************
  lcdcrl_pkg::lcdcrl_state_type  st;
  lcdcrl_pkg::lcdcrl_state_type  next_st;
  lcdcrl_pkg::lcdcrl_decode_type dec;
  logic [15:0]                   stepped_addr;
  logic                          wr_cmd;
  logic                          wr_par;
  logic [4:0]                    wr_ofs;

  assign wr_cmd = host.wr & host.cmd_param_select;   // [RULE22]
  assign wr_par = host.wr & ~host.cmd_param_select;  // [RULE22]
  assign wr_ofs = 5'(st.base + 5'(st.param_idx));

  lcdcrl_decoder lcdcrl_decoder_i (
    .code (host.data),
    .dec  (dec)
  );

  lcdcrl_stepper lcdcrl_stepper_i (
    .addr      (cursor_addr),
    .pitch     (virtual_line_pitch),
    .dir       (cursor_dir),
    .next_addr (stepped_addr)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_st           = st;
    next_st.mem.valid = 1'b0;
    if (wr_cmd) begin
      // every command starts its parameter list afresh
      next_st.cmd       = dec.cmd;
      next_st.base      = dec.base;
      next_st.count     = dec.count;
      next_st.param_idx = 4'h0;                       // [RULE25]
      next_st.rd_high   = 1'b0;
      case (dec.cmd)
        lcdcrl_pkg::LCDCRL_DISP: begin
          next_st.regs[`LCDCRL_OFS_DISP_ENABLE] =
            {7'h00, host.data[0]};                    // [RULE14]
        end
        lcdcrl_pkg::LCDCRL_CSR_STEP: begin
          next_st.regs[`LCDCRL_OFS_CURSOR_STEP_CMD] =
            {6'h00, host.data[1:0]};                  // [RULE20] [RULE23]
        end
        default: begin
        end
      endcase
    end else if (wr_par) begin
      case (st.cmd)
        lcdcrl_pkg::LCDCRL_MEM_WRITE: begin
          // data bytes stream without limit, cursor follows
          next_st.mem.valid = 1'b1;
          next_st.mem.addr  = cursor_addr;
          next_st.mem.data  = host.data;
          next_st.regs[`LCDCRL_OFS_CSR_LOW]  = stepped_addr[7:0];   // [RULE23]
          next_st.regs[`LCDCRL_OFS_CSR_HIGH] = stepped_addr[15:8];  // [RULE23]
        end
        lcdcrl_pkg::LCDCRL_IDLE, lcdcrl_pkg::LCDCRL_UNKNOWN,
        lcdcrl_pkg::LCDCRL_CSR_STEP: begin
        end
        default: begin
          // bytes past the parameter count fall on the floor
          if (st.param_idx < st.count) begin          // [RULE25]
            if (wr_ofs == `LCDCRL_OFS_HSHIFT) begin
              next_st.regs[wr_ofs] =
                host.data & `LCDCRL_MASK_HSHIFT;      // [RULE11]
            end else begin
              // one byte per register, in parameter order
              next_st.regs[wr_ofs] = host.data;       // [RULE1] [RULE2] [RULE3]
            end                                       // [RULE4] [RULE5] [RULE6]
            next_st.param_idx = 4'(st.param_idx + 4'h1);
          end                                         // [RULE7] [RULE8] [RULE9]
        end                                           // [RULE10] [RULE12]
      endcase                                         // [RULE13] [RULE15]
    end                                               // [RULE16] [RULE17]
    // reads with select high return the cursor, low byte first
    if (host.rd && host.cmd_param_select) begin       // [RULE18] [RULE19]
      next_st.rd_data = st.rd_high ? cursor_addr[15:8] : cursor_addr[7:0];
      next_st.rd_high = ~st.rd_high;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st.regs      <= {32{`LCDCRL_REG_RESET}};
      st.cmd       <= lcdcrl_pkg::LCDCRL_IDLE;
      st.base      <= 5'h00;
      st.count     <= 4'h0;
      st.param_idx <= 4'h0;
      st.mem       <= '0;
      st.rd_data   <= 8'h00;
      st.rd_high   <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // field outputs, straight from the flops
  // ****************************************
  assign char_width           = st.regs[`LCDCRL_OFS_CHAR_WIDTH][3:0];
  assign ac_drive_select      = st.regs[`LCDCRL_OFS_CHAR_WIDTH][7];
  assign char_height          = st.regs[`LCDCRL_OFS_CHAR_HEIGHT][3:0];
  assign line_addr_count      = st.regs[`LCDCRL_OFS_LINE_ADDR];
  assign line_total_count     = st.regs[`LCDCRL_OFS_LINE_TOTAL];
  assign frame_line_count     = st.regs[`LCDCRL_OFS_FRAME_LINES];
  assign virtual_line_pitch   = {st.regs[`LCDCRL_OFS_PITCH_HIGH],
                                 st.regs[`LCDCRL_OFS_PITCH_LOW]};
  assign display_enable       = st.regs[`LCDCRL_OFS_DISP_ENABLE][0];
  assign cursor_blink_rate    = st.regs[`LCDCRL_OFS_ATTRIBUTE][1:0];
  assign block1_attr          = st.regs[`LCDCRL_OFS_ATTRIBUTE][3:2];
  assign block2_4_attr        = st.regs[`LCDCRL_OFS_ATTRIBUTE][5:4];
  assign block3_attr          = st.regs[`LCDCRL_OFS_ATTRIBUTE][7:6];
  assign block1_start         = {st.regs[`LCDCRL_OFS_BLK1_HIGH],
                                 st.regs[`LCDCRL_OFS_BLK1_LOW]};
  assign block1_lines         = st.regs[`LCDCRL_OFS_BLK1_LINES];
  assign block2_start         = {st.regs[`LCDCRL_OFS_BLK2_HIGH],
                                 st.regs[`LCDCRL_OFS_BLK2_LOW]};
  assign block2_lines         = st.regs[`LCDCRL_OFS_BLK2_LINES];
  assign block3_start         = {st.regs[`LCDCRL_OFS_BLK3_HIGH],
                                 st.regs[`LCDCRL_OFS_BLK3_LOW]};
  assign block4_start         = {st.regs[`LCDCRL_OFS_BLK4_HIGH],
                                 st.regs[`LCDCRL_OFS_BLK4_LOW]};
  assign cursor_width         = st.regs[`LCDCRL_OFS_CSR_WIDTH][3:0];
  assign cursor_height        = st.regs[`LCDCRL_OFS_CSR_HEIGHT][3:0];
  assign cursor_shape_select  = st.regs[`LCDCRL_OFS_CSR_HEIGHT][7];
  assign cursor_dir           = st.regs[`LCDCRL_OFS_CURSOR_STEP_CMD][1:0];
  assign layer_combine_op     = st.regs[`LCDCRL_OFS_LAYER][1:0];
  assign block1_text_graphics = st.regs[`LCDCRL_OFS_LAYER][2];
  assign fine_hshift          = st.regs[`LCDCRL_OFS_HSHIFT][2:0];
  assign cursor_addr          = {st.regs[`LCDCRL_OFS_CSR_HIGH],
                                 st.regs[`LCDCRL_OFS_CSR_LOW]};
  assign rd_data              = st.rd_data;
  assign mem                  = st.mem;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_init_par(int n);
    wr_par && st.cmd == lcdcrl_pkg::LCDCRL_INIT && st.param_idx == n;
  endsequence

  sequence s_cmd(logic [7:0] code);
    wr_cmd && host.data == code;
  endsequence

  // one idle cycle, then a parameter byte
  sequence s_gap_par;
    !host.wr ##1 wr_par;
  endsequence

  property p_cmd_restart;
    wr_cmd |=> st.param_idx == 4'h0;
  endproperty
  a_cmd_restart: assert property (p_cmd_restart) // [RULE25]
    else $error("parameter index not cleared by command");

  property p_width;
    s_init_par(1) |=> char_width == $past(host.data[3:0])
      && ac_drive_select == $past(host.data[7]);
  endproperty
  a_width: assert property (p_width) // [RULE1]
    else $error("character width or drive bit wrong");

  property p_height_lines;
    s_init_par(2) ##2 s_init_par(3) |=> line_addr_count == $past(host.data)
      && char_height == $past(host.data[3:0], 3);
  endproperty
  a_height_lines: assert property (p_height_lines) // [RULE2] [RULE3]
    else $error("height or line address count wrong");

  property p_pitch;
    s_init_par(6) ##2 s_init_par(7)
      |=> virtual_line_pitch == {$past(host.data), $past(host.data, 3)};
  endproperty
  a_pitch: assert property (p_pitch) // [RULE6]
    else $error("virtual pitch wrong");

  property p_frame;
    s_init_par(4) ##2 s_init_par(5) |=> line_total_count ==
      $past(host.data, 3) && frame_line_count == $past(host.data);
  endproperty
  a_frame: assert property (p_frame) // [RULE4] [RULE5]
    else $error("line total or frame lines wrong");

  property p_scroll_first;
    s_cmd(`LCDCRL_CODE_SCROLL) ##1 s_gap_par ##1 s_gap_par ##1 s_gap_par
      |=> block1_start == {$past(host.data, 3), $past(host.data, 5)}
      && block1_lines == $past(host.data);
  endproperty
  a_scroll_first: assert property (p_scroll_first) // [RULE7] [RULE8]
    else $error("first block start or lines wrong");

  property p_display;
    s_cmd(`LCDCRL_CODE_DISP_ON) ##1 s_gap_par
      |=> display_enable && {block3_attr, block2_4_attr, block1_attr,
      cursor_blink_rate} == $past(host.data);
  endproperty
  a_display: assert property (p_display) // [RULE14] [RULE15] [RULE16]
    else $error("display enable or attributes wrong");

  property p_cursor_load;
    s_cmd(`LCDCRL_CODE_CSR_LOAD) ##1 s_gap_par ##1 s_gap_par
      |=> cursor_addr == {$past(host.data), $past(host.data, 3)};
  endproperty
  a_cursor_load: assert property (p_cursor_load) // [RULE17]
    else $error("cursor address load wrong");

  property p_hshift;
    s_cmd(`LCDCRL_CODE_HSHIFT) ##1 s_gap_par
      |=> fine_hshift == $past(host.data[2:0])
      && st.regs[`LCDCRL_OFS_HSHIFT][7:3] == 5'h00;
  endproperty
  a_hshift: assert property (p_hshift) // [RULE11]
    else $error("fine shift wrong");

  property p_step_down;
    wr_par && st.cmd == lcdcrl_pkg::LCDCRL_MEM_WRITE && cursor_dir == 2'h3
      |=> mem.valid && cursor_addr == 16'($past(cursor_addr)
      + $past(virtual_line_pitch));
  endproperty
  a_step_down: assert property (p_step_down) // [RULE23]
    else $error("downward step did not add pitch");

  property p_step_code;
    wr_cmd && dec.cmd == lcdcrl_pkg::LCDCRL_CSR_STEP
      |=> cursor_dir == $past(host.data[1:0]);
  endproperty
  a_step_code: assert property (p_step_code) // [RULE20]
    else $error("step direction wrong");

  property p_extra_ignored;
    wr_par && st.cmd != lcdcrl_pkg::LCDCRL_MEM_WRITE
      && st.param_idx >= st.count |=> $stable(st.regs);
  endproperty
  a_extra_ignored: assert property (p_extra_ignored) // [RULE25]
    else $error("extra parameter changed a register");

  property p_disp_code;
    wr_cmd && dec.cmd == lcdcrl_pkg::LCDCRL_DISP
      |=> display_enable == $past(host.data[0]);
  endproperty
  a_disp_code: assert property (p_disp_code) // [RULE14]
    else $error("display enable not taken from code");

  property p_layer;
    s_cmd(`LCDCRL_CODE_LAYER) ##1 s_gap_par
      |=> layer_combine_op == $past(host.data[1:0])
      && block1_text_graphics == $past(host.data[2]);
  endproperty
  a_layer: assert property (p_layer) // [RULE12] [RULE13]
    else $error("layer combine or block mode wrong");

  property p_shape;
    s_cmd(`LCDCRL_CODE_CSR_SHAPE) ##1 s_gap_par ##1 s_gap_par
      |=> cursor_width == $past(host.data[3:0], 3)
      && cursor_height == $past(host.data[3:0])
      && cursor_shape_select == $past(host.data[7]);
  endproperty
  a_shape: assert property (p_shape) // [RULE18] [RULE19]
    else $error("cursor shape wrong");

  property p_mem_write;
    wr_par && st.cmd == lcdcrl_pkg::LCDCRL_MEM_WRITE
      |=> mem.valid && mem.addr == $past(cursor_addr)
      && mem.data == $past(host.data);
  endproperty
  a_mem_write: assert property (p_mem_write) // [RULE22]
    else $error("display memory write wrong");

endmodule

// file: sim/lcdcrl_host_model.sv
`timescale 1ns/1ps

module lcdcrl_host_model #(
  parameter bit CRYSTAL = 1'b0
) (
  // clock
  input  wire logic                   clk,
  // host bus toward the device
  output lcdcrl_pkg::lcdcrl_host_type host
);
  // ****************************************
  // bus cycles
  // ****************************************
  initial begin
    host = '0;
  end

  // released select and data lines carry inverted values, strobes drop low, so a stale byte never passes
  task automatic xfer(input logic sel, input logic [7:0] val, input logic w);
    @(posedge clk);
    #1;
    host.wr               = w;
    host.rd               = ~w;
    host.cmd_param_select = sel;
    host.data             = val;
    @(posedge clk);
    #1;
    host.wr               = 1'b0;
    host.rd               = 1'b0;
    host.cmd_param_select = ~sel;
    host.data             = ~val;
  endtask

  task automatic wr_byte(input logic sel, input logic [7:0] val);
    xfer(sel, val, 1'b1);
  endtask

  task automatic rd_byte();
    xfer(1'b1, 8'h00, 1'b0);
  endtask

  // only a crystal needs the settling pause after the init code
  task automatic init_wait();
    if (CRYSTAL) begin
      #3ms;
    end
  endtask

  // short fill stands in for a full layer clear
  task automatic clear_layer(input logic [7:0] fill, input int n);
    wr_byte(1'b1, 8'h42);
    for (int i = 0; i < n; i++) begin
      wr_byte(1'b0, fill);
    end
  endtask
endmodule

// file: sim/lcdcrl_tb.sv
`timescale 1ns/1ps

module lcdcrl_tb;
  logic                        clk;
  logic                        reset_n;
  lcdcrl_pkg::lcdcrl_host_type host;
  lcdcrl_pkg::lcdcrl_mem_type  mem;
  logic [7:0]  rd_data, line_addr_count, line_total_count, frame_line_count;
  logic [7:0]  block1_lines, block2_lines;
  logic [3:0]  char_width, char_height, cursor_width, cursor_height;
  logic [15:0] virtual_line_pitch, block1_start, block2_start;
  logic [15:0] block3_start, block4_start, cursor_addr;
  logic [1:0]  cursor_blink_rate, block1_attr, block2_4_attr, block3_attr;
  logic [1:0]  cursor_dir, layer_combine_op;
  logic [2:0]  fine_hshift;
  logic        ac_drive_select, display_enable, cursor_shape_select;
  logic        block1_text_graphics;
  int          n_mismatch;
  int          checks_done;

  // ****************************************
  // clock, design and host
  // ****************************************
  initial clk = 1'b0;
  always #50 clk = ~clk;

  lcdcrl_top lcdcrl_top_i (.clk(clk), .reset_n(reset_n), .host(host),
    .rd_data(rd_data), .char_width(char_width),
    .ac_drive_select(ac_drive_select), .char_height(char_height),
    .line_addr_count(line_addr_count), .line_total_count(line_total_count),
    .frame_line_count(frame_line_count),
    .virtual_line_pitch(virtual_line_pitch),
    .display_enable(display_enable), .cursor_blink_rate(cursor_blink_rate),
    .block1_attr(block1_attr), .block2_4_attr(block2_4_attr),
    .block3_attr(block3_attr), .block1_start(block1_start),
    .block1_lines(block1_lines), .block2_start(block2_start),
    .block2_lines(block2_lines), .block3_start(block3_start),
    .block4_start(block4_start), .cursor_width(cursor_width),
    .cursor_height(cursor_height), .cursor_shape_select(cursor_shape_select),
    .cursor_dir(cursor_dir), .layer_combine_op(layer_combine_op),
    .block1_text_graphics(block1_text_graphics), .fine_hshift(fine_hshift),
    .cursor_addr(cursor_addr), .mem(mem));

  lcdcrl_host_model lcdcrl_host_model_i (.clk(clk), .host(host));

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string nm, input logic [15:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cmd(input logic [7:0] v);
    lcdcrl_host_model_i.wr_byte(1'b1, v);
  endtask

  task automatic par(input logic [7:0] v);
    lcdcrl_host_model_i.wr_byte(1'b0, v);
  endtask

  task automatic final_report();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  // ninth byte lies past the count and must leave the pitch alone
  task automatic t_init();
    logic [7:0] p [9] = '{8'h38, 8'h87, 8'h07, 8'h3F, 8'h49, 8'h7F,
                          8'h80, 8'h00, 8'h55};
    cmd(8'h40);
    lcdcrl_host_model_i.init_wait();
    foreach (p[i]) par(p[i]);
    chk("char_width", 16'(char_width), 16'h0007);
    chk("ac_drive", 16'(ac_drive_select), 16'h0001);
    chk("char_height", 16'(char_height), 16'h0007);
    chk("line_addr", 16'(line_addr_count), 16'h003F);
    chk("line_total", 16'(line_total_count), 16'h0049);
    chk("frame_lines", 16'(frame_line_count), 16'h007F);
    chk("pitch", virtual_line_pitch, 16'h0080);
  endtask

  task automatic t_scroll();
    logic [7:0] p [10] = '{8'h11, 8'h22, 8'h40, 8'h33, 8'h10, 8'h41,
                           8'h44, 8'h04, 8'h55, 8'h30};
    cmd(8'h44);
    foreach (p[i]) par(p[i]);
    chk("blk1_start", block1_start, 16'h2211);
    chk("blk1_lines", 16'(block1_lines), 16'h0040);
    chk("blk2_start", block2_start, 16'h1033);
    chk("blk2_lines", 16'(block2_lines), 16'h0041);
    chk("blk3_start", block3_start, 16'h0444);
    chk("blk4_start", block4_start, 16'h3055);
  endtask

  // a select-low byte equal to a command code is still a parameter
  task automatic t_shift_layer();
    cmd(8'h5A);
    par(8'hFF);
    chk("hshift", 16'(fine_hshift), 16'h0007);
    cmd(8'h5B);
    par(8'h05);
    par(8'h02);
    chk("combine_op", 16'(layer_combine_op), 16'h0001);
    chk("blk1_mode", 16'(block1_text_graphics), 16'h0001);
    cmd(8'h5B);
    par(8'h59);
    chk("combine_op2", 16'(layer_combine_op), 16'h0001);
    chk("disp_en0", 16'(display_enable), 16'h0000);
    chk("blk1_mode2", 16'(block1_text_graphics), 16'h0000);
  endtask

  task automatic t_display();
    cmd(8'h58);
    par(8'h56);
    chk("disp_off", 16'(display_enable), 16'h0000);
    chk("blink", 16'(cursor_blink_rate), 16'h0002);
    chk("attr1", 16'(block1_attr), 16'h0001);
    chk("attr24", 16'(block2_4_attr), 16'h0001);
    chk("attr3", 16'(block3_attr), 16'h0001);
    lcdcrl_host_model_i.clear_layer(8'h20, 3);
    lcdcrl_host_model_i.clear_layer(8'h00, 3);
    cmd(8'h59);
    chk("disp_on", 16'(display_enable), 16'h0001);
    par(8'hE4);
    chk("attr24_b", 16'(block2_4_attr), 16'h0002);
    chk("attr3_b", 16'(block3_attr), 16'h0003);
    cmd(8'h58);
    chk("disp_off2", 16'(display_enable), 16'h0000);
  endtask

  task automatic t_cursor();
    cmd(8'h46);
    par(8'h01);
    par(8'h10);
    chk("csr_addr", cursor_addr, 16'h1001);
    lcdcrl_host_model_i.rd_byte();
    chk("rd_low", 16'(rd_data), 16'h0001);
    lcdcrl_host_model_i.rd_byte();
    chk("rd_high", 16'(rd_data), 16'h0010);
    cmd(8'h5D);
    par(8'h04);
    par(8'h86);
    chk("csr_width", 16'(cursor_width), 16'h0004);
    chk("csr_height", 16'(cursor_height), 16'h0006);
    chk("csr_block", 16'(cursor_shape_select), 16'h0001);
  endtask

  // every step code, each followed by one memory write
  task automatic t_step();
    logic [15:0] e;
    logic [15:0] d [4] = '{16'h0001, 16'hFFFF, 16'hFF80, 16'h0080};
    e = 16'h1001;
    for (int k = 0; k < 4; k++) begin
      cmd(8'h4C | 8'(k));
      chk("cursor_step_cmd", 16'(cursor_dir), 16'(k));
      cmd(8'h42);
      par(8'hA0 + 8'(k));
      chk("mem_valid", 16'(mem.valid), 16'h0001);
      chk("mem_addr", mem.addr, e);
      chk("mem_data", 16'(mem.data), 16'h00A0 + 16'(k));
      e = e + d[k];
      chk("csr_step", cursor_addr, e);
      @(posedge clk);
      #1;
      chk("mem_idle", 16'(mem.valid), 16'h0000);
    end
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    n_mismatch  = 0;
    checks_done = 0;
    reset_n     = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    reset_n = 1'b1;
    chk("rst_cursor", cursor_addr, 16'h0000);
    chk("rst_mem", 16'(mem.valid), 16'h0000);
    t_init();
    t_scroll();
    t_shift_layer();
    t_display();
    t_cursor();
    t_step();
    final_report();
  end

  // run needs about 130 cycles; allow ample margin
  initial begin
    #200us;
    n_mismatch++;
    final_report();
  end
endmodule
